// file: logic/fdhc_drive.sv
// Behaviour
// - spindle runs while gated motor-run asserted
// - index interval checked against speed window
// - erase gate delayed after write gate
// - track zero needs phase A, step-out
// - 48 tpi: two motor steps per pulse
// - 48 tpi: phase B briefly on parity
// - 96 tpi: one motor step per pulse
// - 96 tpi: phase B on tracks 1+4n
// - old and new phase overlap 0.6 ms
// - index output pulses per hole, stretched
// - read pulses follow flux spacing
// - write protect follows masked notch
// - direction latched at each step pulse
// - 48 tpi second step 3 ms after pulse ends
// - ready on second index after half speed
// - write needs notch, gate, selection
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module fdhc_drive #(
  parameter int ERASE_ON_STD = fdhc_pkg::ERASE_ON_STD_CYC,
  parameter int ERASE_ON_HD = fdhc_pkg::ERASE_ON_HD_CYC,
  parameter int ERASE_OFF_STD = fdhc_pkg::ERASE_OFF_STD_CYC,
  parameter int ERASE_OFF_HD = fdhc_pkg::ERASE_OFF_HD_CYC,
  parameter int STEP2 = fdhc_pkg::STEP2_CYC,
  parameter int OVERLAP = fdhc_pkg::OVERLAP_CYC,
  parameter int IDX_W_STD = fdhc_pkg::IDX_W_STD_CYC,
  parameter int IDX_W_HD = fdhc_pkg::IDX_W_HD_CYC,
  parameter int IDX_LO_STD = fdhc_pkg::IDX_LO_STD_CYC,
  parameter int IDX_HI_STD = fdhc_pkg::IDX_HI_STD_CYC,
  parameter int IDX_LO_HD = fdhc_pkg::IDX_LO_HD_CYC,
  parameter int IDX_HI_HD = fdhc_pkg::IDX_HI_HD_CYC,
  parameter int HALF_STD = fdhc_pkg::HALF_STD_CYC,
  parameter int HALF_HD = fdhc_pkg::HALF_HD_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic motor_on,
  input wire logic drive_sel,
  input wire logic step,
  input wire logic dir_in,
  input wire logic write_gate,
  input wire logic trk0_sensor,
  input wire logic index_hole,
  input wire logic notch_open,
  input wire logic rd_flux,
  output logic spindle_run,
  output logic write_en,
  output logic erase_gate,
  output logic [3:0] phase_drive,
  output logic phase_b_probe,
  output logic track0_b,
  output logic index_b,
  output logic read_data_b,
  output logic write_protect_b,
  output logic ready_b
);
  typedef fdhc_pkg::fdhc_cnt_t cnt_t;

  // one-hot coil pattern of a phase
  function automatic logic [3:0] fdhc_onehot(input logic [1:0] p);
    return 4'h1 << p;
  endfunction : fdhc_onehot

  // pick the model's count
  function automatic cnt_t fdhc_pick(input logic hd, input int s, input int h);
    return hd ? cnt_t'(h) : cnt_t'(s);
  endfunction : fdhc_pick

  // reset release through two flops
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // registers
  logic [3:0] ctrl;
  logic [fdhc_pkg::IRQ_W-1:0] irq_stat;
  logic [fdhc_pkg::IRQ_W-1:0] irq_mask;
  logic [7:0] track_pos;
  logic hd;
  logic tpi96;
  assign hd = ctrl[fdhc_pkg::CTRL_HD];
  assign tpi96 = ctrl[fdhc_pkg::CTRL_TPI96];

  // model-dependent terminal counts
  wire cnt_t erase_on_len = fdhc_pick(hd, ERASE_ON_STD, ERASE_ON_HD);
  wire cnt_t erase_off_len = fdhc_pick(hd, ERASE_OFF_STD, ERASE_OFF_HD);
  wire cnt_t idx_w_len = fdhc_pick(hd, IDX_W_STD, IDX_W_HD);
  wire cnt_t idx_lo = fdhc_pick(hd, IDX_LO_STD, IDX_LO_HD);
  wire cnt_t idx_hi = fdhc_pick(hd, IDX_HI_STD, IDX_HI_HD);
  wire cnt_t half_len = fdhc_pick(hd, HALF_STD, HALF_HD);
  wire cnt_t rd_w_len = fdhc_pick(hd, fdhc_pkg::RD_W_STD_CYC, fdhc_pkg::RD_W_HD_CYC);

  // apb decode
  wire apb_setup = psel && !penable;
  wire apb_acc = psel && penable;
  wire hit_ctrl = (paddr == fdhc_pkg::ADDR_CTRL);
  wire hit_status = (paddr == fdhc_pkg::ADDR_STATUS);
  wire hit_istat = (paddr == fdhc_pkg::ADDR_IRQ_STAT);
  wire hit_imask = (paddr == fdhc_pkg::ADDR_IRQ_MASK);
  wire hit_track = (paddr == fdhc_pkg::ADDR_TRACK);
  wire hit_any = hit_ctrl | hit_status | hit_istat | hit_imask | hit_track;
  wire wr_ok = apb_acc && pwrite && hit_any;
  assign pready = 1'b1;
  assign pslverr = apb_acc && !hit_any;

  // input edge history
  logic step_q;
  logic idx_q;
  logic rd_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 1'b0;
      idx_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      step_q <= step;
      idx_q <= index_hole;
      rd_q <= rd_flux;
    end
  end
  wire step_rise = step && !step_q;
  wire step_fall = !step && step_q;
  wire idx_edge = index_hole && !idx_q;
  wire rd_edge = rd_flux && !rd_q;

  // spindle and write qualification
  wire spin_req = motor_on && ctrl[fdhc_pkg::CTRL_SPIN_GATE];
  wire sel_ok = drive_sel || ctrl[fdhc_pkg::CTRL_ALWAYS_SEL];
  wire write_ok = notch_open && write_gate && sel_ok;

  // erase gate delay counter
  cnt_t erase_cnt;
  wire cnt_t erase_lim = write_ok ? erase_on_len : erase_off_len;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      erase_gate <= 1'b0;
      erase_cnt <= '0;
    end else if (write_ok == erase_gate) begin
      erase_cnt <= '0;
    end else if (erase_cnt >= erase_lim) begin
      erase_gate <= write_ok;
      erase_cnt <= '0;
    end else begin
      erase_cnt <= erase_cnt + 1'b1;
    end
  end

  // direction latch, high means step-out
  logic dir_out;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_out <= 1'b1;
    end else if (step_rise) begin
      dir_out <= dir_in;
    end
  end

  // second internal step for 48 tpi
  logic step2_done;
  fdhc_timer u_step2 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(step_fall && !tpi96),
    .len(cnt_t'(STEP2)),
    .busy(),
    .done(step2_done)
  );

  // motor step events: external, plus the second one in 48 tpi
  wire mstep = step_rise || (step2_done && !tpi96);
  // an external step moves with the direction sampled at its own edge,
  // the second internal step with the latched one
  wire dir_now = step_rise ? dir_in : dir_out;
  wire ph_inc = tpi96 ? !dir_now : dir_now;

  // phase sequencer with overlap
  fdhc_pkg::fdhc_phase_t phase;
  fdhc_pkg::fdhc_phase_t phase_old;
  logic ovl_busy;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase <= fdhc_pkg::FDHC_PH_A;
      phase_old <= fdhc_pkg::FDHC_PH_A;
    end else if (mstep) begin
      phase_old <= phase;
      phase <= fdhc_pkg::fdhc_phase_t'(ph_inc ? phase + 2'h1 : phase - 2'h1);
    end
  end

  fdhc_timer u_overlap (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(mstep),
    .len(cnt_t'(OVERLAP)),
    .busy(ovl_busy),
    .done()
  );

  // coil drive: new phase, old phase too during overlap
  wire [3:0] next_drive = fdhc_onehot(phase) | (ovl_busy ? fdhc_onehot(phase_old) : 4'h0);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_drive <= 4'h1;
    end else begin
      phase_drive <= next_drive;
    end
  end
  assign phase_b_probe = phase_drive[fdhc_pkg::FDHC_PH_B];

  // head position, one count per external step
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      track_pos <= 8'h00;
    end else if (step_rise && dir_in && track_pos != 8'h00) begin
      track_pos <= track_pos - 8'h01;
    end else if (step_rise && !dir_in && track_pos != 8'hff) begin
      track_pos <= track_pos + 8'h01;
    end
  end

  // index stretch and read pulse shaping
  logic idx_busy;
  logic rd_busy;
  fdhc_timer u_idx (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(idx_edge),
    .len(idx_w_len),
    .busy(idx_busy),
    .done()
  );
  fdhc_timer u_rd (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(rd_edge),
    .len(rd_w_len),
    .busy(rd_busy),
    .done()
  );

  // speed detector and ready
  logic ready;
  logic speed_ok;
  logic speed_err;
  fdhc_spd_mon u_spd (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(spin_req),
    .idx_edge(idx_edge),
    .lo(idx_lo),
    .hi(idx_hi),
    .half(half_len),
    .ready(ready),
    .speed_ok(speed_ok),
    .speed_err(speed_err)
  );

  // interface outputs
  logic ready_q;
  wire trk0_next = trk0_sensor && (phase == fdhc_pkg::FDHC_PH_A) && dir_out;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spindle_run <= 1'b0;
      write_en <= 1'b0;
      track0_b <= 1'b1;
      index_b <= 1'b1;
      read_data_b <= 1'b1;
      write_protect_b <= 1'b1;
      ready_b <= 1'b1;
      ready_q <= 1'b0;
    end else begin
      spindle_run <= spin_req;
      write_en <= write_ok;
      track0_b <= !trk0_next;
      index_b <= !idx_busy;
      read_data_b <= !(rd_busy && !write_en);
      write_protect_b <= notch_open;
      ready_b <= !ready;
      ready_q <= ready;
    end
  end

  // sticky events, write one to clear, set wins
  wire [fdhc_pkg::IRQ_W-1:0] ev = {mstep, speed_err, ready != ready_q, idx_edge};
  wire [fdhc_pkg::IRQ_W-1:0] clr = (wr_ok && hit_istat) ? pwdata[fdhc_pkg::IRQ_W-1:0] : '0;
  assign irq = |(irq_stat & irq_mask);

  // register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= fdhc_pkg::CTRL_RST;
      irq_mask <= '0;
      irq_stat <= '0;
    end else begin
      irq_stat <= (irq_stat & ~clr) | ev;
      if (wr_ok && hit_ctrl) begin
        ctrl <= pwdata[3:0];
      end
      if (wr_ok && hit_imask) begin
        irq_mask <= pwdata[fdhc_pkg::IRQ_W-1:0];
      end
    end
  end

  // read mux, captured in the setup cycle
  wire [31:0] status_word = {19'h0, speed_ok, ready, erase_gate, write_en,
                             !write_protect_b, !track0_b, dir_out, phase_drive, phase};
  wire [31:0] rd_mux = hit_ctrl ? {28'h0, ctrl} :
                       hit_status ? status_word :
                       hit_istat ? {28'h0, irq_stat} :
                       hit_imask ? {28'h0, irq_mask} :
                       hit_track ? {24'h0, track_pos} : 32'h0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (apb_setup) begin
      prdata <= rd_mux;
    end
  end
endmodule : fdhc_drive
`default_nettype wire

// file: logic/fdhc_pkg.sv
package fdhc_pkg;
  // clock
  localparam int CLK_MHZ = 125;
  localparam int CLK_NS = 8;
  localparam int CNT_W = 26;
  typedef logic [CNT_W-1:0] fdhc_cnt_t;
  // erase gate delays, microseconds
  localparam int ERASE_ON_STD_US = 200;
  localparam int ERASE_ON_HD_US = 175;
  localparam int ERASE_OFF_STD_US = 860;
  localparam int ERASE_OFF_HD_US = 500;
  localparam int ERASE_ON_STD_CYC = ERASE_ON_STD_US * CLK_MHZ;
  localparam int ERASE_ON_HD_CYC = ERASE_ON_HD_US * CLK_MHZ;
  localparam int ERASE_OFF_STD_CYC = ERASE_OFF_STD_US * CLK_MHZ;
  localparam int ERASE_OFF_HD_CYC = ERASE_OFF_HD_US * CLK_MHZ;
  // stepping timing, microseconds
  localparam int STEP2_US = 3000;
  localparam int OVERLAP_US = 600;
  localparam int STEP2_CYC = STEP2_US * CLK_MHZ;
  localparam int OVERLAP_CYC = OVERLAP_US * CLK_MHZ;
  // index pulse width (least) and interval window, microseconds
  localparam int IDX_W_STD_US = 2000;
  localparam int IDX_W_HD_US = 1000;
  localparam int IDX_LO_STD_US = 197000;
  localparam int IDX_HI_STD_US = 203000;
  localparam int IDX_LO_HD_US = 164200;
  localparam int IDX_HI_HD_US = 169200;
  localparam int IDX_W_STD_CYC = IDX_W_STD_US * CLK_MHZ;
  localparam int IDX_W_HD_CYC = IDX_W_HD_US * CLK_MHZ;
  localparam int IDX_LO_STD_CYC = IDX_LO_STD_US * CLK_MHZ;
  localparam int IDX_HI_STD_CYC = IDX_HI_STD_US * CLK_MHZ;
  localparam int IDX_LO_HD_CYC = IDX_LO_HD_US * CLK_MHZ;
  localparam int IDX_HI_HD_CYC = IDX_HI_HD_US * CLK_MHZ;
  // half rated speed: interval below twice the window's upper limit
  localparam int HALF_STD_CYC = 2 * IDX_HI_STD_CYC;
  localparam int HALF_HD_CYC = 2 * IDX_HI_HD_CYC;
  // read data pulse width, nanoseconds
  localparam int RD_W_STD_NS = 1000;
  localparam int RD_W_HD_NS = 500;
  localparam int RD_W_STD_CYC = (RD_W_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_W_HD_CYC = (RD_W_HD_NS + CLK_NS - 1) / CLK_NS;
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_TRACK = 8'h10;
  // control fields and reset value
  localparam int CTRL_HD = 0;
  localparam int CTRL_TPI96 = 1;
  localparam int CTRL_ALWAYS_SEL = 2;
  localparam int CTRL_SPIN_GATE = 3;
  localparam logic [3:0] CTRL_RST = 4'h8;
  // interrupt event bits
  localparam int IRQ_W = 4;
  localparam int EV_INDEX = 0;
  localparam int EV_READY = 1;
  localparam int EV_SPEED = 2;
  localparam int EV_STEP = 3;
  // stepping motor phases
  typedef enum logic [1:0] {
    FDHC_PH_A = 2'b00,
    FDHC_PH_B = 2'b01,
    FDHC_PH_C = 2'b10,
    FDHC_PH_D = 2'b11
  } fdhc_phase_t;
endpackage : fdhc_pkg

// file: logic/fdhc_spd_mon.sv
`timescale 1ns/1ns
`default_nettype none
module fdhc_spd_mon (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic idx_edge,
  input wire fdhc_pkg::fdhc_cnt_t lo,
  input wire fdhc_pkg::fdhc_cnt_t hi,
  input wire fdhc_pkg::fdhc_cnt_t half,
  output logic ready,
  output logic speed_ok,
  output logic speed_err
);
  fdhc_pkg::fdhc_cnt_t cnt;
  logic seen;
  logic half_ok;
  logic [1:0] idx_n;
  wire in_win = (cnt >= lo) && (cnt <= hi);
  wire fast_half = seen && (cnt < half);

  // interval counter, saturating at the half-speed limit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      seen <= 1'b0;
    end else if (!run) begin
      cnt <= '0;
      seen <= 1'b0;
    end else if (idx_edge) begin
      cnt <= '0;
      seen <= 1'b1;
    end else if (cnt < half) begin
      cnt <= cnt + 1'b1;
    end
  end

  // speed detector, pre-ready and ready latches
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_ok <= 1'b0;
      idx_n <= 2'h0;
      speed_ok <= 1'b0;
    end else if (!run || (cnt >= half)) begin
      half_ok <= 1'b0;
      idx_n <= 2'h0;
      speed_ok <= 1'b0;
    end else if (idx_edge) begin
      half_ok <= fast_half;
      speed_ok <= seen && in_win;
      if (half_ok && idx_n != 2'h2) begin
        idx_n <= idx_n + 2'h1;
      end
    end
  end

  assign ready = (idx_n == 2'h2);
  assign speed_err = idx_edge && half_ok && !in_win;
endmodule : fdhc_spd_mon
`default_nettype wire

// file: logic/fdhc_timer.sv
`timescale 1ns/1ns
`default_nettype none
module fdhc_timer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire fdhc_pkg::fdhc_cnt_t len,
  output logic busy,
  output logic done
);
  fdhc_pkg::fdhc_cnt_t cnt;

  // down counter, retriggered by start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (start) begin
      cnt <= len;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  // busy while running, done on last count
  assign busy = (cnt != '0);
  assign done = (cnt == fdhc_pkg::fdhc_cnt_t'(1)) && !start;
endmodule : fdhc_timer
`default_nettype wire

// file: tb/fdhc_drive_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module fdhc_drive_chk #(
  parameter int EON = 16,
  parameter int EOFF = 60,
  parameter int OV = 30,
  parameter int IW = 20
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic motor_on,
  input wire logic step,
  input wire logic write_gate,
  input wire logic trk0_sensor,
  input wire logic notch_open,
  input wire logic spindle_run,
  input wire logic write_en,
  input wire logic erase_gate,
  input wire logic [3:0] phase_drive,
  input wire logic track0_b,
  input wire logic index_b,
  input wire logic write_protect_b
);
  int lv, whi, wlo, ov, ilo;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // run lengths of gate, overlap and index levels
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lv <= 0;
      whi <= 0;
      wlo <= 0;
      ov <= 0;
      ilo <= 0;
    end else begin
      lv <= (lv < 7) ? lv + 1 : lv;
      whi <= write_gate ? whi + 1 : 0;
      wlo <= write_gate ? 0 : wlo + 1;
      ov <= ($countones(phase_drive) == 2) ? ov + 1 : 0;
      ilo <= index_b ? 0 : ilo + 1;
    end
  end
  a_spin_stop: assert property ((lv > 4 && !motor_on) [*3] |-> !spindle_run)
    else $error("spindle runs without motor request");
  a_protect_map: assert property ((lv > 4 && $stable(notch_open)) [*3] |-> write_protect_b == notch_open)
    else $error("write protect does not follow notch");
  a_write_notch: assert property ((lv > 4 && !notch_open) [*3] |-> !write_en)
    else $error("write permitted on masked notch");
  a_trk0_qual: assert property (!track0_b |-> $past(trk0_sensor) || $past(trk0_sensor, 2))
    else $error("track zero without sensor");
  a_erase_on: assert property ($rose(erase_gate) |-> whi >= EON)
    else $error("erase gate rose too early");
  a_erase_off: assert property (wlo > EOFF + 4 |-> !erase_gate)
    else $error("erase gate held too long");
  a_overlap_len: assert property (ov <= OV + 2)
    else $error("two phase drive too long");
  a_step_moves: assert property ($rose(step) |-> ##[1:3] ($countones(phase_drive) == 2))
    else $error("step did not start phase overlap");
  a_index_width: assert property ($rose(index_b) |-> ilo >= IW - 1)
    else $error("index pulse too short");
  a_slverr_phase: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
endmodule : fdhc_drive_chk
bind fdhc_drive fdhc_drive_chk #(.EON(ERASE_ON_HD), .EOFF(ERASE_OFF_STD), .OV(OVERLAP), .IW(IDX_W_HD)) chk_u (
  .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pslverr(pslverr), .motor_on(motor_on),
  .step(step), .write_gate(write_gate), .trk0_sensor(trk0_sensor), .notch_open(notch_open),
  .spindle_run(spindle_run), .write_en(write_en), .erase_gate(erase_gate), .phase_drive(phase_drive),
  .track0_b(track0_b), .index_b(index_b), .write_protect_b(write_protect_b));
`default_nettype wire

// file: tb/fdhc_drive_tb.sv
`timescale 1ns/1ns
`default_nettype none
module fdhc_drive_tb;
  localparam int EON = 20;
  localparam int EOFF = 60;
  localparam int OV = 30;
  localparam int IW = 40;
  localparam int RW = fdhc_pkg::RD_W_STD_CYC;
  localparam int EON_HD = 16, EOFF_HD = 40, STP2 = 100, IW_HD = 20;
  localparam int LO = 900, HI = 1100, LO_HD = 750, HI_HD = 920, HALF = 2200, HALF_HD = 1840;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slv;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, motor_on, drive_sel, step, dir_in, write_gate;
  logic trk0_sensor = 1'h1, index_hole = 1'h0, notch_open = 1'h1, rd_flux = 1'h0;
  logic spindle_run, write_en, erase_gate, phase_b_probe, track0_b, index_b, read_data_b, write_protect_b, ready_b;
  logic [3:0] phase_drive;
  int err_total = 0, n_compared = 0, n, rdn = 0;
  fdhc_host host_u (.clk_sys(clk_sys), .motor_on(motor_on), .drive_sel(drive_sel), .step(step), .dir_in(dir_in),
    .write_gate(write_gate));
  fdhc_drive #(.ERASE_ON_STD(EON), .ERASE_ON_HD(EON_HD), .ERASE_OFF_STD(EOFF), .ERASE_OFF_HD(EOFF_HD),
    .STEP2(STP2), .OVERLAP(OV), .IDX_W_STD(IW), .IDX_W_HD(IW_HD), .IDX_LO_STD(LO), .IDX_HI_STD(HI),
    .IDX_LO_HD(LO_HD), .IDX_HI_HD(HI_HD), .HALF_STD(HALF), .HALF_HD(HALF_HD)) dut_u (.clk_sys(clk_sys),
    .rst_b(rst_b), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .motor_on(motor_on), .drive_sel(drive_sel), .step(step), .dir_in(dir_in),
    .write_gate(write_gate), .trk0_sensor(trk0_sensor), .index_hole(index_hole), .notch_open(notch_open),
    .rd_flux(rd_flux), .spindle_run(spindle_run), .write_en(write_en), .erase_gate(erase_gate),
    .phase_drive(phase_drive), .phase_b_probe(phase_b_probe), .track0_b(track0_b), .index_b(index_b),
    .read_data_b(read_data_b), .write_protect_b(write_protect_b), .ready_b(ready_b));
  // 125 mhz clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // read pulse counter
  always @(negedge read_data_b) rdn++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc
  // one apb transfer, setup then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'h1 && t < 50);
    r = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // bounded wait for a level, n counts cycles
  task automatic upto(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : upto
  task automatic flux(input int g);
    rd_flux <= 1'h1;
    cyc(1);
    rd_flux <= 1'h0;
    cyc(g);
  endtask : flux
  task automatic stp(input logic out, input logic [3:0] ov, input logic [3:0] nw);
    host_u.pulse(out);
    chk(phase_drive, ov);
    cyc(OV + 5);
    chk(phase_drive, nw);
    chk(phase_b_probe, nw[1]);
  endtask : stp
  task automatic s_regs();
    chk(phase_drive, 4'h1);
    chk(track0_b, 1'h0);
    apb(1'h0, fdhc_pkg::ADDR_CTRL, 32'h0);
    chk(r, 32'h8);
    apb(1'h0, 8'h20, 32'h0);
    chk(r, 32'h0);
    chk(slv, 1'h1);
  endtask : s_regs
  task automatic s_spin();
    host_u.lines(1'h1, 1'h1, 1'h0);
    cyc(5);
    chk(spindle_run, 1'h1);
    apb(1'h1, fdhc_pkg::ADDR_CTRL, 32'h0);
    cyc(5);
    chk(spindle_run, 1'h0);
    apb(1'h1, fdhc_pkg::ADDR_CTRL, 32'h8);
    host_u.lines(1'h0, 1'h1, 1'h0);
    cyc(5);
    chk(spindle_run, 1'h0);
  endtask : s_spin
  task automatic s_write();
    notch_open <= 1'h0;
    host_u.lines(1'h0, 1'h1, 1'h1);
    cyc(5);
    chk(write_protect_b, 1'h0);
    chk(write_en, 1'h0);
    notch_open <= 1'h1;
    cyc(5);
    chk(write_protect_b, 1'h1);
    chk(write_en, 1'h1);
    host_u.lines(1'h0, 1'h0, 1'h1);
    cyc(5);
    chk(write_en, 1'h0);
    apb(1'h1, fdhc_pkg::ADDR_CTRL, 32'hc);
    cyc(5);
    chk(write_en, 1'h1);
    host_u.lines(1'h0, 1'h1, 1'h0);
    apb(1'h1, fdhc_pkg::ADDR_CTRL, 32'h8);
    cyc(100);
    host_u.lines(1'h0, 1'h1, 1'h1);
    upto(erase_gate, 1'h1, 500);
    chk(n >= EON && n <= EON + 5, 1'h1);
    host_u.lines(1'h0, 1'h1, 1'h0);
    upto(erase_gate, 1'h0, 500);
    chk(n >= EOFF && n <= EOFF + 5, 1'h1);
    // high-density model delays
    apb(1'h1, fdhc_pkg::ADDR_CTRL, 32'h9);
    host_u.lines(1'h0, 1'h1, 1'h1);
    upto(erase_gate, 1'h1, 500);
    chk(n >= EON_HD && n <= EON_HD + 5, 1'h1);
    host_u.lines(1'h0, 1'h1, 1'h0);
    upto(erase_gate, 1'h0, 500);
    chk(n >= EOFF_HD && n <= EOFF_HD + 5, 1'h1);
    apb(1'h1, fdhc_pkg::ADDR_CTRL, 32'h8);
  endtask : s_write
  task automatic s_step();
    apb(1'h1, fdhc_pkg::ADDR_CTRL, 32'ha);
    trk0_sensor <= 1'h0;
    stp(1'h0, 4'h3, 4'h2);
    stp(1'h0, 4'h6, 4'h4);
    stp(1'h1, 4'h6, 4'h2);
    stp(1'h1, 4'h3, 4'h1);
    trk0_sensor <= 1'h1;
    cyc(3);
    chk(track0_b, 1'h0);
    stp(1'h0, 4'h3, 4'h2);
    chk(track0_b, 1'h1);
    stp(1'h1, 4'h3, 4'h1);
    chk(track0_b, 1'h0);
    apb(1'h1, fdhc_pkg::ADDR_CTRL, 32'h8);
    stp(1'h1, 4'h3, 4'h2);
    cyc(40);
    chk(phase_drive, 4'h2);
    cyc(60);
    chk(phase_drive, 4'h4);
  endtask : s_step
  task automatic s_index();
    apb(1'h1, fdhc_pkg::ADDR_IRQ_MASK, 32'h1);
    host_u.lines(1'h1, 1'h1, 1'h0);
    repeat (5) begin
      index_hole <= 1'h1;
      cyc(10);
      index_hole <= 1'h0;
      cyc(990);
    end
    chk(ready_b, 1'h0);
    chk(irq, 1'h1);
    apb(1'h1, fdhc_pkg::ADDR_IRQ_STAT, 32'h1);
    apb(1'h1, fdhc_pkg::ADDR_IRQ_MASK, 32'h0);
    cyc(1);
    chk(irq, 1'h0);
    index_hole <= 1'h1;
    upto(index_b, 1'h0, 20);
    upto(index_b, 1'h1, 200);
    chk(n >= IW && n <= IW + 1, 1'h1);
    index_hole <= 1'h0;
    chk(irq, 1'h0);
    apb(1'h0, fdhc_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(r[0], 1'h1);
    apb(1'h0, fdhc_pkg::ADDR_STATUS, 32'h0);
    chk(r[12], 1'h1);
    host_u.lines(1'h0, 1'h1, 1'h0);
    cyc(5);
    chk(ready_b, 1'h1);
  endtask : s_index
  task automatic s_read();
    rdn = 0;
    flux(500);
    flux(1000);
    flux(500);
    chk(rdn, 32'h3);
    rd_flux <= 1'h1;
    upto(read_data_b, 1'h0, 10);
    rd_flux <= 1'h0;
    upto(read_data_b, 1'h1, 300);
    chk(n >= RW && n <= RW + 1, 1'h1);
    host_u.lines(1'h0, 1'h1, 1'h1);
    cyc(5);
    rdn = 0;
    flux(200);
    chk(rdn, 32'h0);
    host_u.lines(1'h0, 1'h1, 1'h0);
  endtask : s_read
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  // reset, then the scenarios in turn
  initial begin
    cyc(20);
    rst_b <= 1'h1;
    cyc(4);
    s_regs();
    s_spin();
    s_write();
    s_step();
    s_index();
    s_read();
    finish_test();
  end
  // watchdog
  initial begin
    cyc(40000);
    err_total++;
    finish_test();
  end
endmodule : fdhc_drive_tb
`default_nettype wire

// file: tb/fdhc_host.sv
`timescale 1ns/1ns
`default_nettype none
module fdhc_host (
  input wire logic clk_sys,
  output logic motor_on,
  output logic drive_sel,
  output logic step,
  output logic dir_in,
  output logic write_gate
);
  // idle lines at time zero
  initial begin
    motor_on = 1'h0;
    drive_sel = 1'h0;
    step = 1'h0;
    dir_in = 1'h1;
    write_gate = 1'h0;
  end
  // level commands, called just after an edge
  task automatic lines(input logic m, input logic s, input logic w);
    motor_on <= m;
    drive_sel <= s;
    write_gate <= w;
  endtask : lines
  // direction settles a cycle ahead of the step edge
  task automatic pulse(input logic out);
    dir_in <= out;
    @(posedge clk_sys);
    step <= 1'h1;
    repeat (8) @(posedge clk_sys);
    step <= 1'h0;
    @(posedge clk_sys);
  endtask : pulse
endmodule : fdhc_host
`default_nettype wire
